//--- rtl/aafd_decoder.sv
/*
 Ancillary function decoder: fetches the four-word host command block
 by DMA, runs function codes 2..7, 10 and 11, filters frame addresses.
 Assumes a single-word DMA port on sys_clk that holds off with dma_ack.
*/
// Strobed register access and the address map are this design's own decisions.
// Notes on behaviour
// - code 2 returns factory address
// - factory words at offsets 2, 4, 6
// - factory address fixed, separate from station
// - code 3 does nothing
// - code 4 reads, 5 writes station address
// - frames filtered against station address
// - station words at 2, 4, 6; bit0 zero
// - code 6 reads, 7 writes group table
// - at most ten group entries
// - entry count at offset 4 high byte
// - group write with zero count clears
// - group read truncated to requested count
// - data block base from offsets 2, 4
// - code 10 reads, 11 writes ring spec
// - ring read returns held parameters
// - function code low byte, never altered
`default_nettype none
module aafd_decoder #(
    parameter logic [47:0] FACTORY_ADDRESS = aafd_pkg::FACTORY_DEFAULT,
    parameter int GROUP_ENTRIES = aafd_pkg::GROUP_MAX
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // host memory dma
    output logic dma_valid,
    output var aafd_pkg::aafd_dma_cmd_type dma_cmd,
    input wire logic dma_ack,
    input wire logic [15:0] dma_rdata,
    // receive filter
    input wire logic frame_dest_valid,
    input wire logic [47:0] frame_dest,
    output logic frame_result_valid,
    output logic frame_accept,
    // held parameters
    output var aafd_pkg::aafd_ring_spec_type ring_spec,
    output logic [47:0] station_address
);
    import aafd_pkg::*;

    aafd_state_type state_reg;
    aafd_dma_cmd_type dma_cmd_reg;
    logic dma_valid_reg;
    logic [15:0] cmd_reg [4];
    logic [15:0] cbb_lo_reg;
    logic [15:0] cbb_hi_reg;
    logic [47:0] sa_reg;
    logic [47:0] grp_reg [GROUP_ENTRIES];
    logic [7:0] grp_count_reg;
    logic [15:0] ring_reg [6];
    logic [5:0] wcnt_reg;
    logic [5:0] len_reg;
    logic [3:0] ent_reg;
    logic [1:0] sub_reg;
    logic done_reg;
    logic err_reg;
    logic [15:0] rdata_reg;
    logic accept_reg;
    logic result_valid_reg;

    // decode wires
    logic [7:0] fc;
    logic [17:0] cbb;
    logic [17:0] host_data_block_base;
    logic [7:0] req_count;
    logic [7:0] grp_req;
    logic [7:0] grp_rd_n;
    logic [47:0] sa_load;
    logic start;
    logic clear_done;
    logic xfer_rd;
    logic exec_go;
    logic [5:0] wcnt_inc;
    logic sub_wrap;
    logic [3:0] ent_nxt;
    logic [1:0] sub_nxt;
    logic [15:0] rd_mux;
    logic [5:0] exec_len;
    logic [17:0] exec_base;
    logic exec_write;
    logic exec_err;
    logic [GROUP_ENTRIES-1:0] grp_hit;
    logic dest_hit;

    assign fc = cmd_reg[0][7:0];
    assign cbb = {cbb_hi_reg[1:0], cbb_lo_reg[15:1], 1'b0};
    assign host_data_block_base = {cmd_reg[2][1:0], cmd_reg[1][15:1], 1'b0};
    assign req_count = cmd_reg[2][15:8];
    assign grp_req = (req_count > 8'(GROUP_ENTRIES)) ? 8'(GROUP_ENTRIES) : req_count;
    assign grp_rd_n = (grp_req < grp_count_reg) ? grp_req : grp_count_reg;
    // bit 0 dropped even if the host sets it
    assign sa_load = {cmd_reg[3], cmd_reg[2], cmd_reg[1] & LOW_WORD_MASK};
    assign start = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START_BIT] && state_reg == ST_IDLE;
    assign clear_done = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLEAR_BIT];
    assign xfer_rd = state_reg == ST_XFER && dma_ack && !dma_cmd_reg.write;
    assign exec_go = state_reg == ST_EXEC;
    assign wcnt_inc = 6'(wcnt_reg + 6'h01);
    assign sub_wrap = sub_reg == 2'h2;
    assign ent_nxt = sub_wrap ? 4'(ent_reg + 4'h1) : ent_reg;
    assign sub_nxt = sub_wrap ? 2'h0 : 2'(sub_reg + 2'h1);

    function automatic logic [15:0] word_of(input logic [47:0] a, input logic [1:0] i);
        word_of = (i == 2'h0) ? a[15:0] : (i == 2'h1) ? a[31:16] : a[47:32];
    endfunction

    // outgoing word for write-back index w, group entry e, word s
    function automatic logic [15:0] src_word(input logic [5:0] w, input logic [3:0] e,
                                             input logic [1:0] s);
        logic [47:0] ent;
        ent = (int'(e) < GROUP_ENTRIES) ? grp_reg[e] : 48'h0000_0000_0000;
        case (fc)
            FC_READ_FACTORY: src_word = word_of(FACTORY_ADDRESS, w[1:0]);
            FC_READ_STATION: src_word = word_of(sa_reg, w[1:0]);
            FC_READ_GROUP: src_word = word_of(ent, s);
            FC_READ_RING: src_word = (w < RING_WORDS) ? ring_reg[w[2:0]] : 16'h0000;
            default: src_word = 16'h0000;
        endcase
    endfunction

    always_comb begin
        exec_len = 6'h00;
        exec_base = host_data_block_base;
        exec_write = 1'b0;
        exec_err = 1'b0;
        case (fc)
            FC_READ_FACTORY, FC_READ_STATION: begin
                // results go after the code word, which stays untouched
                exec_len = ADDR_WORDS;
                exec_base = 18'(cbb + WORD_STEP);
                exec_write = 1'b1;
            end
            FC_NOP, FC_WRITE_STATION: begin
                exec_len = 6'h00;
            end
            FC_READ_GROUP: begin
                exec_len = 6'(grp_rd_n * 3);
                exec_write = 1'b1;
            end
            FC_WRITE_GROUP: begin
                exec_len = 6'(grp_req * 3);
            end
            FC_READ_RING: begin
                exec_len = RING_WORDS;
                exec_write = 1'b1;
            end
            FC_WRITE_RING: begin
                exec_len = RING_WORDS;
            end
            default: begin
                exec_err = 1'b1;
            end
        endcase
    end

    // sequencer: fetch four words, decode, move the data block
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            wcnt_reg <= 6'h00;
            len_reg <= 6'h00;
            ent_reg <= 4'h0;
            sub_reg <= 2'h0;
            dma_valid_reg <= 1'b0;
            dma_cmd_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_FETCH;
                        wcnt_reg <= 6'h00;
                        dma_valid_reg <= 1'b1;
                        dma_cmd_reg <= '{write: 1'b0, addr: cbb, data: 16'h0000};
                    end
                end
                ST_FETCH: begin
                    if (dma_ack && wcnt_reg == FETCH_LAST) begin
                        state_reg <= ST_EXEC;
                        dma_valid_reg <= 1'b0;
                    end else if (dma_ack) begin
                        wcnt_reg <= wcnt_inc;
                        dma_cmd_reg.addr <= 18'(dma_cmd_reg.addr + WORD_STEP);
                    end
                end
                ST_EXEC: begin
                    wcnt_reg <= 6'h00;
                    ent_reg <= 4'h0;
                    sub_reg <= 2'h0;
                    len_reg <= exec_len;
                    if (exec_len == 6'h00) begin
                        state_reg <= ST_DONE;
                    end else begin
                        state_reg <= ST_XFER;
                        dma_valid_reg <= 1'b1;
                        dma_cmd_reg <= '{write: exec_write, addr: exec_base, data: src_word(6'h00, 4'h0, 2'h0)};
                    end
                end
                ST_XFER: begin
                    // done only after the last word is taken
                    if (dma_ack && wcnt_inc == len_reg) begin
                        state_reg <= ST_DONE;
                        dma_valid_reg <= 1'b0;
                    end else if (dma_ack) begin
                        wcnt_reg <= wcnt_inc;
                        ent_reg <= ent_nxt;
                        sub_reg <= sub_nxt;
                        dma_cmd_reg.addr <= 18'(dma_cmd_reg.addr + WORD_STEP);
                        dma_cmd_reg.data <= src_word(wcnt_inc, ent_nxt, sub_nxt);
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_reg <= '{default: 16'h0000};
        end else if (state_reg == ST_FETCH && dma_ack) begin
            cmd_reg[wcnt_reg[1:0]] <= dma_rdata;
        end
    end

    // reset loads the factory value; later only code 5 changes it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sa_reg <= FACTORY_ADDRESS;
        end else if (exec_go && fc == FC_WRITE_STATION) begin
            sa_reg <= sa_load;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            grp_count_reg <= 8'h00;
            grp_reg <= '{default: 48'h0000_0000_0000};
        end else if (exec_go && fc == FC_WRITE_GROUP) begin
            // whole table wiped, so a zero count leaves nothing behind
            grp_count_reg <= grp_req;
            grp_reg <= '{default: 48'h0000_0000_0000};
        end else if (xfer_rd && fc == FC_WRITE_GROUP) begin
            grp_reg[ent_reg][16*sub_reg +: 16] <= dma_rdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ring_reg <= '{default: 16'h0000};
        end else if (xfer_rd && fc == FC_WRITE_RING) begin
            ring_reg[wcnt_reg[2:0]] <= dma_rdata & RING_MASK[wcnt_reg[2:0]];
        end
    end

    // register port
    always_comb begin
        case (reg_addr)
            REG_CTRL: rd_mux = {fc, 5'h00, err_reg, done_reg, state_reg != ST_IDLE};
            REG_CBB_LO: rd_mux = cbb_lo_reg;
            REG_CBB_HI: rd_mux = cbb_hi_reg;
            REG_GROUP_COUNT: rd_mux = {8'h00, grp_count_reg};
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cbb_lo_reg <= 16'h0000;
            cbb_hi_reg <= 16'h0000;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            // base frozen while a command runs
            if (reg_wr && reg_addr == REG_CBB_LO && state_reg == ST_IDLE) begin
                cbb_lo_reg <= reg_wdata & LOW_WORD_MASK;
            end
            if (reg_wr && reg_addr == REG_CBB_HI && state_reg == ST_IDLE) begin
                cbb_hi_reg <= reg_wdata & CBB_HI_MASK;
            end
            // set wins over a clear in the same cycle
            if (state_reg == ST_DONE) begin
                done_reg <= 1'b1;
            end else if (clear_done) begin
                done_reg <= 1'b0;
            end
            if (exec_go && exec_err) begin
                err_reg <= 1'b1;
            end else if (clear_done) begin
                err_reg <= 1'b0;
            end
            rdata_reg <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // frame filter
    generate
        for (genvar g = 0; g < GROUP_ENTRIES; g++) begin : g_grp
            assign grp_hit[g] = (8'(g) < grp_count_reg) && (grp_reg[g] == frame_dest);
        end
    endgenerate
    assign dest_hit = (frame_dest == sa_reg) || (|grp_hit);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result_valid_reg <= 1'b0;
            accept_reg <= 1'b0;
        end else begin
            result_valid_reg <= frame_dest_valid;
            accept_reg <= frame_dest_valid && dest_hit;
        end
    end

    assign reg_rdata = rdata_reg;
    assign dma_valid = dma_valid_reg;
    assign dma_cmd = dma_cmd_reg;
    assign frame_result_valid = result_valid_reg;
    assign frame_accept = accept_reg;
    assign station_address = sa_reg;
    assign ring_spec = '{tx_base: {ring_reg[1][1:0], ring_reg[0][15:1], 1'b0},
                         tx_entry_words: ring_reg[1][15:8],
                         tx_entry_count: ring_reg[2],
                         rx_base: {ring_reg[4][1:0], ring_reg[3][15:1], 1'b0},
                         rx_entry_words: ring_reg[4][15:8],
                         receive_ring_entry_count: ring_reg[5]};

    default clocking aafd_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    AST_FETCH_FIRST: assert property (start |=> dma_valid && !dma_cmd.write && dma_cmd.addr == $past(cbb))
        else $error("fetch did not begin at block base");
    AST_EXEC_AFTER_FETCH: assert property ((state_reg == ST_FETCH && dma_ack && wcnt_reg == FETCH_LAST)
        |=> state_reg == ST_EXEC && !dma_valid) else $error("no decode after fourth word");
    AST_NOP: assert property ((exec_go && fc == FC_NOP) |=> state_reg == ST_DONE ##1 !dma_valid)
        else $error("no-op caused activity");
    AST_CODE_KEPT: assert property ((dma_valid && dma_cmd.write) |-> dma_cmd.addr != cbb)
        else $error("code word overwritten");
    AST_FACTORY_LOW: assert property ((dma_valid && dma_cmd.write && fc == FC_READ_FACTORY
        && dma_cmd.addr == 18'(cbb + WORD_STEP)) |-> dma_cmd.data == FACTORY_ADDRESS[15:0])
        else $error("factory low word wrong");
    AST_STATION_LOAD: assert property ((exec_go && fc == FC_WRITE_STATION) |=> sa_reg == $past(sa_load))
        else $error("station address not loaded");
    AST_STATION_BIT0: assert property ($rose(done_reg) |-> sa_reg[0] == 1'b0)
        else $error("station address bit 0 set");
    AST_GROUP_LIMIT: assert property (grp_count_reg <= 8'(GROUP_ENTRIES))
        else $error("group count above table size");
    AST_GROUP_CLEAR: assert property ((exec_go && fc == FC_WRITE_GROUP && req_count == 8'h00)
        |=> grp_count_reg == 8'h00 && state_reg == ST_DONE) else $error("group table not cleared");
    AST_GROUP_TRUNC: assert property ((exec_go && fc == FC_READ_GROUP) |=> len_reg == 6'($past(grp_rd_n) * 3))
        else $error("group read length wrong");
    AST_ACCEPT: assert property ((frame_dest_valid && frame_dest == sa_reg) |=> frame_accept && frame_result_valid)
        else $error("own frame rejected");
    AST_DONE_FLAG: assert property ((state_reg == ST_DONE) |=> done_reg && state_reg == ST_IDLE)
        else $error("done flag not set");
    COV_FACTORY: cover property (exec_go && fc == FC_READ_FACTORY ##[1:40] state_reg == ST_DONE);
    COV_GROUP_LOAD: cover property (xfer_rd && fc == FC_WRITE_GROUP && ent_reg == 4'h1);
    COV_RING_LOAD: cover property (xfer_rd && fc == FC_WRITE_RING && wcnt_reg == 6'h05);
    COV_GROUP_HIT: cover property (frame_dest_valid && |grp_hit);
endmodule
`default_nettype wire

//--- rtl/aafd_pkg.sv
/*
 Shared constants and types for the ancillary function decoder.
 Assumes 16-bit host words, byte addressing and 18-bit host addresses.
*/
`default_nettype none
package aafd_pkg;
    // function codes
    localparam logic [7:0] FC_READ_FACTORY = 8'h02;
    localparam logic [7:0] FC_NOP = 8'h03;
    localparam logic [7:0] FC_READ_STATION = 8'h04;
    localparam logic [7:0] FC_WRITE_STATION = 8'h05;
    localparam logic [7:0] FC_READ_GROUP = 8'h06;
    localparam logic [7:0] FC_WRITE_GROUP = 8'h07;
    localparam logic [7:0] FC_READ_RING = 8'h0A;
    localparam logic [7:0] FC_WRITE_RING = 8'h0B;
    // register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CBB_LO = 4'h1;
    localparam logic [3:0] REG_CBB_HI = 4'h2;
    localparam logic [3:0] REG_GROUP_COUNT = 4'h3;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    // field masks
    localparam logic [15:0] LOW_WORD_MASK = 16'hFFFE;
    localparam logic [15:0] CBB_HI_MASK = 16'h0003;
    localparam logic [15:0] RING_MASK [6] = '{16'hFFFE, 16'hFF03, 16'hFFFF,
                                             16'hFFFE, 16'hFF03, 16'hFFFF};
    // sizes and steps
    localparam int GROUP_MAX = 10;
    localparam logic [17:0] WORD_STEP = 18'h00002;
    localparam logic [5:0] FETCH_LAST = 6'h03;
    localparam logic [5:0] ADDR_WORDS = 6'h03;
    localparam logic [5:0] RING_WORDS = 6'h06;
    // arbitrary value, bit 0 clear
    localparam logic [47:0] FACTORY_DEFAULT = 48'h02A0_5C31_7E40;

    typedef struct packed {
        logic write;
        logic [17:0] addr;
        logic [15:0] data;
    } aafd_dma_cmd_type;

    typedef struct packed {
        logic [17:0] tx_base;
        logic [7:0] tx_entry_words;
        logic [15:0] tx_entry_count;
        logic [17:0] rx_base;
        logic [7:0] rx_entry_words;
        logic [15:0] receive_ring_entry_count;
    } aafd_ring_spec_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_EXEC = 3'b011,
        ST_XFER = 3'b010,
        ST_DONE = 3'b110
    } aafd_state_type;
endpackage
`default_nettype wire

//--- tb/aafd_host_mem.sv
/*
 Host memory model on the far side of the decoder's DMA port.
 Assumes 18-bit byte addresses of 16-bit words; slow acks every other cycle.
*/
`default_nettype none
module aafd_host_mem (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // dma port
    input wire logic dma_valid,
    input wire aafd_pkg::aafd_dma_cmd_type dma_cmd,
    input wire logic slow,
    output logic dma_ack,
    output logic [15:0] dma_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import aafd_pkg::*;
    logic [15:0] mem [0:131071];
    logic [7:0] tick;
    assign dma_ack = dma_valid && (!slow || tick[0]);
    // data churns outside an ack so a stale word never passes for a real one
    assign dma_rdata = (dma_ack && !dma_cmd.write) ? mem[dma_cmd.addr[17:1]] : {tick, ~tick};
    always_ff @(posedge sys_clk) begin
        tick <= rst_n ? tick + 8'h01 : 8'h00;
        if (dma_ack && dma_cmd.write) begin
            mem[dma_cmd.addr[17:1]] <= dma_cmd.data;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_ancillary_address_function_decoder.sv
/*
 Self-checking bench for the ancillary function decoder.
 Assumes the host memory model and the package; command block base set once.
*/
`default_nettype none
module tb_ancillary_address_function_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    import aafd_pkg::*;
    localparam logic [47:0] FACT = 48'h0B1C_2D3E_4F50;
    localparam logic [17:0] CBB = 18'h2_0100;
    localparam logic [17:0] HOST_DATA_BLOCK = 18'h1_0040;
    localparam logic [16:0] CBI = CBB[17:1];
    localparam logic [16:0] UBI = HOST_DATA_BLOCK[17:1];
    localparam logic [47:0] SA = 48'h6A5B_4C3D_2E1E;
    localparam logic [47:0] G0 = 48'h0300_1234_5601;
    localparam logic [47:0] G1 = 48'h0300_ABCD_EF01;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic dma_valid;
    aafd_dma_cmd_type dma_cmd;
    logic dma_ack;
    logic [15:0] dma_rdata;
    logic frame_dest_valid = 1'b0;
    logic [47:0] frame_dest = 48'h0;
    logic frame_result_valid;
    logic frame_accept;
    aafd_ring_spec_type ring_spec;
    logic [47:0] station_address;
    logic slow = 1'b0;
    logic [15:0] d;
    logic [15:0] rw [6] = '{16'h1235, 16'h08FD, 16'h0020, 16'h4561, 16'h04FE, 16'h0002};
    int n_fail = 0;
    int num_checks = 0;
    int acks = 0;

    aafd_decoder #(.FACTORY_ADDRESS(FACT), .GROUP_ENTRIES(GROUP_MAX)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_valid(dma_valid),
        .dma_cmd(dma_cmd), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
        .frame_dest_valid(frame_dest_valid), .frame_dest(frame_dest),
        .frame_result_valid(frame_result_valid), .frame_accept(frame_accept),
        .ring_spec(ring_spec), .station_address(station_address));
    aafd_host_mem mem_model (.sys_clk(sys_clk), .rst_n(rst_n), .dma_valid(dma_valid),
        .dma_cmd(dma_cmd), .slow(slow), .dma_ack(dma_ack), .dma_rdata(dma_rdata));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (dma_valid && dma_ack) acks <= acks + 1;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_val(input string what, input logic [99:0] exp, input logic [99:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_blk3(input string what, input logic [47:0] exp, input logic [16:0] b);
        chk_word(what, exp[15:0], mem_model.mem[b]);
        chk_word(what, exp[31:16], mem_model.mem[b + 17'd1]);
        chk_word(what, exp[47:32], mem_model.mem[b + 17'd2]);
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic frame(input logic [47:0] dest, input logic exp);
        @(posedge sys_clk);
        frame_dest <= dest;
        frame_dest_valid <= 1'b1;
        @(posedge sys_clk);
        frame_dest_valid <= 1'b0;
        #1 chk_val("frame", {1'b1, exp}, {frame_result_valid, frame_accept});
    endtask
    // host fills the block, starts, then polls done with a bounded count
    task automatic run(input logic [7:0] fc, input logic [15:0] w1, w2, w3, input int n, input logic err);
        logic [15:0] st;
        int i;
        mem_model.mem[CBI] = {8'h00, fc};
        mem_model.mem[CBI + 17'd1] = w1;
        mem_model.mem[CBI + 17'd2] = w2;
        mem_model.mem[CBI + 17'd3] = w3;
        acks = 0;
        reg_write(REG_CTRL, 16'h0002);
        reg_write(REG_CTRL, 16'h0001);
        st = 16'h0000;
        i = 0;
        while (st[1] !== 1'b1 && i < 100) begin
            reg_read(REG_CTRL, st);
            i++;
        end
        chk_word("ctrl", {fc, 5'h00, err, 2'b10}, st);
        chk_val("dma words", 100'(n), 100'(acks));
        chk_word("code word", {8'h00, fc}, mem_model.mem[CBI]);
    endtask
    task automatic fill(input int n, input logic [15:0] base);
        for (int i = 0; i < n; i++) mem_model.mem[UBI + 17'(i)] = base + 16'(i);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk_val("station", FACT, station_address);
        chk_val("ring", 100'h0, ring_spec);
        reg_read(REG_GROUP_COUNT, d);
        chk_word("groups", 16'h0000, d);
        reg_read(4'hF, d);
        chk_word("unmapped", 16'h0000, d);
        // stray low bit and reserved_zero bits must be dropped by the base registers
        reg_write(REG_CBB_LO, CBB[15:0] | 16'h0001);
        reg_write(REG_CBB_HI, {14'h3FFF, CBB[17:16]});
        reg_read(REG_CBB_LO, d);
        chk_word("cbb lo", CBB[15:0], d);
        reg_read(REG_CBB_HI, d);
        chk_word("cbb hi", {14'h0, CBB[17:16]}, d);
        run(FC_READ_FACTORY, 16'hAAAA, 16'hBBBB, 16'hCCCC, 7, 1'b0);
        chk_blk3("factory", FACT, CBI + 17'd1);
        run(FC_NOP, 16'h1111, 16'h2222, 16'h3333, 4, 1'b0);
        chk_blk3("nop", 48'h3333_2222_1111, CBI + 17'd1);
        chk_val("station", FACT, station_address);
        run(FC_WRITE_STATION, SA[15:0], SA[31:16], SA[47:32], 4, 1'b0);
        chk_val("station", SA, station_address);
        run(FC_READ_STATION, 16'h0000, 16'h0000, 16'h0000, 7, 1'b0);
        chk_blk3("station rd", SA, CBI + 17'd1);
        run(FC_READ_FACTORY, 16'h0000, 16'h0000, 16'h0000, 7, 1'b0);
        chk_blk3("factory", FACT, CBI + 17'd1);
        frame(SA, 1'b1);
        frame(FACT, 1'b0);
        fill(36, 16'h1000);
        run(FC_WRITE_GROUP, HOST_DATA_BLOCK[15:0], {8'd12, 6'h00, HOST_DATA_BLOCK[17:16]}, 16'h0000, 34, 1'b0);
        reg_read(REG_GROUP_COUNT, d);
        chk_word("groups", 16'd10, d);
        {mem_model.mem[UBI + 17'd2], mem_model.mem[UBI + 17'd1], mem_model.mem[UBI]} = G0;
        {mem_model.mem[UBI + 17'd5], mem_model.mem[UBI + 17'd4], mem_model.mem[UBI + 17'd3]} = G1;
        run(FC_WRITE_GROUP, HOST_DATA_BLOCK[15:0], {8'd2, 6'h3F, HOST_DATA_BLOCK[17:16]}, 16'h0000, 10, 1'b0);
        reg_read(REG_GROUP_COUNT, d);
        chk_word("groups", 16'd2, d);
        frame(G1, 1'b1);
        fill(6, 16'hDE00);
        run(FC_READ_GROUP, HOST_DATA_BLOCK[15:0], {8'd1, 6'h00, HOST_DATA_BLOCK[17:16]}, 16'h0000, 7, 1'b0);
        chk_blk3("group rd", G0, UBI);
        chk_word("past end", 16'hDE03, mem_model.mem[UBI + 17'd3]);
        run(FC_WRITE_GROUP, HOST_DATA_BLOCK[15:0], {8'd0, 6'h00, HOST_DATA_BLOCK[17:16]}, 16'h0000, 4, 1'b0);
        reg_read(REG_GROUP_COUNT, d);
        chk_word("groups", 16'd0, d);
        frame(G1, 1'b0);
        for (int i = 0; i < 6; i++) mem_model.mem[UBI + 17'(i)] = rw[i];
        run(FC_WRITE_RING, HOST_DATA_BLOCK[15:0], {8'hFF, 6'h00, HOST_DATA_BLOCK[17:16]}, 16'h0000, 10, 1'b0);
        chk_val("ring", {18'h1_1234, 8'h08, 16'h0020, 18'h2_4560, 8'h04, 16'h0002}, ring_spec);
        fill(6, 16'hDE00);
        slow <= 1'b1;
        run(FC_READ_RING, HOST_DATA_BLOCK[15:0], {8'h00, 6'h00, HOST_DATA_BLOCK[17:16]}, 16'h0000, 10, 1'b0);
        slow <= 1'b0;
        for (int i = 0; i < 6; i++) chk_word("ring rd", rw[i] & RING_MASK[i], mem_model.mem[UBI + 17'(i)]);
        run(8'h09, 16'h0000, 16'h0000, 16'h0000, 4, 1'b1);
        report_and_stop();
    end
    initial begin
        #100000;
        n_fail++;
        $display("timeout");
        report_and_stop();
    end
endmodule
`default_nettype wire
